/* File: hw/pci_user_ctl.sv */
// user-side master read path and target controls of the embedded pci core, with an apb register slave
// assumes one clock serves as both pci clock and user fifo clock, and all user inputs are on it
`default_nettype none
`include "pci_user_consts.svh"

module pci_user_ctl #(
  parameter int                         WIDTH         = 64,
  parameter int                         DEPTH         = 32,
  parameter logic [`DISCARD_TIMER_W-1:0] DISCARD_LIMIT = `DISCARD_LIMIT_DEF
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  // apb slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // read data from the pci engine
  input  wire logic             pci_rd_valid_i,
  input  wire logic [WIDTH-1:0] pci_rd_data_i,
  input  wire logic             pci_rd_last_i,
  output logic                  pci_rd_ready_o,
  // master read fifo, user side
  input  wire logic             rd_data_en_n_i,
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  rd_data_valid_o,
  output logic                  rd_last_cyc_n_o,
  output logic                  rd_fifo_empty_n_o,
  output logic                  rd_fifo_almost_empty_n_o,
  output logic                  rd_fifo_full_n_o,
  // master stop burst
  input  wire logic             stop_burst_n_i,
  output logic                  burst_stop_o,
  // target requests from user logic
  input  wire logic             tgt_abort_req_i,
  input  wire logic             tgt_retry_req_n_i,
  input  wire logic             tgt_delayed_req_i,
  input  wire logic             tgt_is_mem_write_i,
  input  wire logic             dt_done_i,
  // target actions toward the pci engine
  output logic                  tgt_abort_o,
  output logic                  tgt_retry_o,
  output logic                  dt_start_o,
  output logic                  dt_new_txn_o,
  output logic                  disc_timer_exp_n_o,
  // status events and serial status
  input  wire logic             evt_tabort_i,
  input  wire logic             evt_serr_i,
  input  wire logic             evt_perr_i,
  input  wire logic             stat_shift_en_n_i,
  output logic                  status_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // saturating count of cycles a request has been held
  function automatic logic [1:0] hold_inc(input logic [1:0] cnt, input logic req);
    hold_inc = !req ? 2'h0 : (cnt == 2'h3) ? 2'h3 : cnt + 2'h1;
  endfunction : hold_inc

  // true on the cycle a request completes its minimum hold
  function automatic logic hold_done(input logic [1:0] cnt, input logic req);
    hold_done = req && (cnt == 2'(`REQ_HOLD_CYCLES - 1));
  endfunction : hold_done

  ////////////////////////////////////////////////////////////////////////////
  // master read fifo

  rd_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_rd_fifo (
    .ref_clk_i        (ref_clk_i),
    .srst_i           (srst_i),
    .wr_valid_i       (pci_rd_valid_i),
    .wr_data_i        (pci_rd_data_i),
    .wr_last_i        (pci_rd_last_i),
    .wr_ready_o       (pci_rd_ready_o),
    .rd_en_n_i        (rd_data_en_n_i),
    .rd_data_o        (rd_data_o),
    .rd_valid_o       (rd_data_valid_o),
    .rd_last_cyc_n_o  (rd_last_cyc_n_o),
    .empty_n_o        (rd_fifo_empty_n_o),
    .almost_empty_n_o (rd_fifo_almost_empty_n_o),
    .full_n_o         (rd_fifo_full_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request hold counters

  logic [1:0] stop_cnt_r;
  logic [1:0] abort_cnt_r;
  logic [1:0] retry_cnt_r;
  logic [1:0] dt_cnt_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stop_cnt_r  <= 2'h0;
      abort_cnt_r <= 2'h0;
      retry_cnt_r <= 2'h0;
      dt_cnt_r    <= 2'h0;
    end else begin
      stop_cnt_r  <= hold_inc(stop_cnt_r, !stop_burst_n_i);
      abort_cnt_r <= hold_inc(abort_cnt_r, tgt_abort_req_i);
      retry_cnt_r <= hold_inc(retry_cnt_r, !tgt_retry_req_n_i);
      dt_cnt_r    <= hold_inc(dt_cnt_r, tgt_delayed_req_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop burst and retry: act once the minimum hold is reached, end with the request

  // the user keeps the request until the full flag rises, so dropping it simply ends the stop
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      burst_stop_o <= 1'b0;
      tgt_retry_o  <= 1'b0;
    end else begin
      burst_stop_o <= !stop_burst_n_i && (stop_cnt_r != 2'h0);
      tgt_retry_o  <= !tgt_retry_req_n_i && (retry_cnt_r != 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // abort: sticky until reset or a software clear

  logic abort_clr;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tgt_abort_o <= 1'b0;
    end else if (hold_done(abort_cnt_r, tgt_abort_req_i)) begin
      tgt_abort_o <= 1'b1;
    end else if (abort_clr) begin
      tgt_abort_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delayed transaction and discard timer

  pci_user_pkg::dt_state_t      dt_state_r;
  logic [`DISCARD_TIMER_W-1:0] dt_timer_r;
  logic                        dt_accept;

  // memory writes are posted, so a delayed request for one is ignored
  assign dt_accept = hold_done(dt_cnt_r, tgt_delayed_req_i) && !tgt_is_mem_write_i;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dt_state_r   <= pci_user_pkg::DT_IDLE;
      dt_timer_r   <= '0;
      dt_start_o   <= 1'b0;
      dt_new_txn_o <= 1'b0;
    end else begin
      dt_start_o   <= 1'b0;
      dt_new_txn_o <= 1'b0;
      case (dt_state_r)
        pci_user_pkg::DT_IDLE: begin
          if (dt_accept) begin
            dt_state_r <= pci_user_pkg::DT_RUN;
            dt_timer_r <= '0;
            dt_start_o <= 1'b1;
          end
        end
        pci_user_pkg::DT_RUN: begin
          if (dt_done_i) begin
            dt_state_r <= pci_user_pkg::DT_IDLE;
          end else if (dt_timer_r == DISCARD_LIMIT) begin
            dt_state_r <= pci_user_pkg::DT_EXPIRED;
          end else begin
            dt_timer_r <= dt_timer_r + 1'b1;
          end
        end
        pci_user_pkg::DT_EXPIRED: begin
          // the old transaction is discarded; the retry starts from scratch
          if (dt_accept) begin
            dt_state_r   <= pci_user_pkg::DT_RUN;
            dt_timer_r   <= '0;
            dt_start_o   <= 1'b1;
            dt_new_txn_o <= 1'b1;
          end
        end
        default: begin
          dt_state_r <= pci_user_pkg::DT_IDLE;
        end
      endcase
    end
  end

  assign disc_timer_exp_n_o = (dt_state_r != pci_user_pkg::DT_EXPIRED);

  ////////////////////////////////////////////////////////////////////////////
  // status events and serial status output

  logic [`EVT_NUM-1:0] evt_r;
  logic [`EVT_NUM-1:0] evt_in;
  logic [`EVT_NUM-1:0] evt_clr;
  logic [`EVT_NUM-1:0] mask_r;
  logic [1:0]          shift_idx_r;

  always_comb begin
    evt_in              = '0;
    evt_in[`EVT_TABORT] = evt_tabort_i;
    evt_in[`EVT_SERR]   = evt_serr_i;
    evt_in[`EVT_PERR]   = evt_perr_i;
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      evt_r <= '0;
    end else begin
      evt_r <= (evt_r & ~evt_clr) | evt_in;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      shift_idx_r <= 2'h0;
      status_o    <= 1'b0;
    end else if (stat_shift_en_n_i) begin
      shift_idx_r <= 2'h0;
      status_o    <= |(evt_r & mask_r);
    end else begin
      status_o    <= evt_r[shift_idx_r];
      shift_idx_r <= (shift_idx_r == 2'(`EVT_NUM - 1)) ? 2'h0 : shift_idx_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register slave, zero wait states

  logic wr_en;
  logic rd_en;
  logic hit;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign hit   = (paddr_i == `REG_CTRL_OFS) || (paddr_i == `REG_STATUS_OFS) || (paddr_i == `REG_TIMER_OFS);

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;
  assign abort_clr = wr_en && (paddr_i == `REG_CTRL_OFS) && pwdata_i[`CTRL_ABORT_CLR_BIT];
  assign evt_clr   = (wr_en && (paddr_i == `REG_STATUS_OFS)) ? pwdata_i[`STAT_EVT_LSB +: `EVT_NUM] : '0;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mask_r <= `CTRL_MASK_RST;
    end else if (wr_en && (paddr_i == `REG_CTRL_OFS)) begin
      mask_r <= pwdata_i[`CTRL_MASK_LSB +: `CTRL_MASK_W];
    end
  end

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (rd_en) begin
      case (paddr_i)
        `REG_CTRL_OFS: begin
          prdata_o[`CTRL_MASK_LSB +: `CTRL_MASK_W] = mask_r;
        end
        `REG_STATUS_OFS: begin
          prdata_o[`STAT_EVT_LSB +: `EVT_NUM] = evt_r;
          prdata_o[`STAT_EMPTY_BIT]           = rd_fifo_empty_n_o;
          prdata_o[`STAT_AEMPTY_BIT]          = rd_fifo_almost_empty_n_o;
          prdata_o[`STAT_FULL_BIT]            = rd_fifo_full_n_o;
          prdata_o[`STAT_ABORT_BIT]           = tgt_abort_o;
          prdata_o[`STAT_EXPIRED_BIT]         = !disc_timer_exp_n_o;
          prdata_o[`STAT_DT_RUN_BIT]          = (dt_state_r == pci_user_pkg::DT_RUN);
        end
        `REG_TIMER_OFS: begin
          prdata_o[`DISCARD_TIMER_W-1:0] = dt_timer_r;
        end
        default: begin
          prdata_o = 32'h0000_0000;
        end
      endcase
    end
  end

endmodule : pci_user_ctl

`default_nettype wire

/* File: hw/pci_user_consts.svh */
// offsets, field positions, reset values and timing counts for the pci user-side control block
// assumes an apb slave with 32-bit data and one aligned word per register
`ifndef PCI_USER_CONSTS_SVH
`define PCI_USER_CONSTS_SVH

// register byte offsets
`define REG_CTRL_OFS        12'h000
`define REG_STATUS_OFS      12'h004
`define REG_TIMER_OFS       12'h008

// ctrl fields
`define CTRL_MASK_LSB       0
`define CTRL_MASK_W         3
`define CTRL_ABORT_CLR_BIT  4
`define CTRL_MASK_RST       3'h7

// status fields
`define STAT_EVT_LSB        0
`define STAT_EMPTY_BIT      4
`define STAT_AEMPTY_BIT     5
`define STAT_FULL_BIT       6
`define STAT_ABORT_BIT      8
`define STAT_EXPIRED_BIT    9
`define STAT_DT_RUN_BIT     10

// status event bit order on the status output
`define EVT_TABORT          0
`define EVT_SERR            1
`define EVT_PERR            2
`define EVT_NUM             3

// fifo flag level and timing
`define RD_AEMPTY_LEVEL     4
`define REQ_HOLD_CYCLES     2
`define DISCARD_TIMER_W     15
`define DISCARD_LIMIT_DEF   15'h7FFF

`endif

/* File: hw/pci_user_pkg.sv */
// types shared by the pci user-side control block
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package pci_user_pkg;

  typedef enum logic [1:0] {
    DT_IDLE    = 2'b00,
    DT_RUN     = 2'b01,
    DT_EXPIRED = 2'b10
  } dt_state_t;

endpackage : pci_user_pkg

`default_nettype wire

/* File: hw/rd_fifo.sv */
// master read data fifo with the user-side flags and last-cycle marker
// assumes the pci engine and the user logic share ref_clk_i
`default_nettype none
`include "pci_user_consts.svh"

module rd_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  // filling side, from the pci engine
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_last_i,
  output logic                  wr_ready_o,
  // draining side, user logic
  input  wire logic             rd_en_n_i,
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  rd_valid_o,
  output logic                  rd_last_cyc_n_o,
  // flags
  output logic                  empty_n_o,
  output logic                  almost_empty_n_o,
  output logic                  full_n_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 * `RD_AEMPTY_LEVEL || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rd_fifo: DEPTH must be a power of two of at least eight");
  end

  logic [WIDTH:0]  mem_r [DEPTH];
  logic [AW-1:0]   wptr_r;
  logic [AW-1:0]   rptr_r;
  logic [AW:0]     count_r;
  logic            push;
  logic            pop;

  assign push       = wr_valid_i && full_n_o;
  assign pop        = !rd_en_n_i && empty_n_o;
  assign wr_ready_o = full_n_o;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wptr_r] <= {wr_last_i, wr_data_i};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // marker travels with its word so that a burst of several words marks only the final word
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_data_o       <= '0;
      rd_valid_o      <= 1'b0;
      rd_last_cyc_n_o <= 1'b1;
    end else begin
      rd_valid_o      <= pop;
      rd_last_cyc_n_o <= !(pop && mem_r[rptr_r][WIDTH]);
      if (pop) begin
        rd_data_o <= mem_r[rptr_r][WIDTH-1:0];
      end
    end
  end

  // flags are registered from the next count
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      empty_n_o        <= 1'b0;
      almost_empty_n_o <= 1'b0;
      full_n_o         <= 1'b1;
    end else begin
      empty_n_o        <= (count_r + (AW+1)'(push) - (AW+1)'(pop)) != '0;
      almost_empty_n_o <= (count_r + (AW+1)'(push) - (AW+1)'(pop)) > (AW+1)'(`RD_AEMPTY_LEVEL);
      full_n_o         <= (count_r + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
    end
  end

endmodule : rd_fifo

`default_nettype wire

/* File: verification/user_req_model.sv */
// user logic model: holds one stop-burst or target request for three clock cycles per go pulse, the last stop-burst cycle extended while the read fifo is full
// assumes go_i is a one-cycle pulse on ref_clk_i and the read fifo full flag is visible
`default_nettype none
module user_req_model (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // command from the bench
  input  wire logic       go_i,
  input  wire logic [1:0] kind_i,
  input  wire logic       full_n_i,
  // requests toward the core
  output logic            stop_burst_n_o,
  output logic            abort_req_o,
  output logic            retry_req_n_o,
  output logic            delayed_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] kind_r = 2'h0;
  logic [1:0] left_r = 2'h0;
  logic       busy;
  // three cycles, one above the minimum hold; stop-burst also waits for the full flag to rise
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      left_r <= 2'h0;
    end else if (go_i) begin
      left_r <= 2'h3;
      kind_r <= kind_i;
    end else if (busy && !(left_r == 2'h1 && kind_r == 2'h0 && !full_n_i)) begin
      left_r <= left_r - 2'h1;
    end
  end
  assign busy           = (left_r != 2'h0);
  assign stop_burst_n_o = !(busy && kind_r == 2'h0);
  assign abort_req_o    = busy && kind_r == 2'h1;
  assign retry_req_n_o  = !(busy && kind_r == 2'h2);
  assign delayed_req_o  = busy && kind_r == 2'h3;
endmodule : user_req_model
`default_nettype wire

/* File: verification/pci_user_ctl_props.sv */
// assertions on read fifo flags and target request handling of pci_user_ctl
// assumes one clock for pci and user sides and srst_i synchronous active high
`default_nettype none
module pci_user_ctl_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // read fifo
  input wire logic pci_rd_ready_o,
  input wire logic rd_data_en_n_i,
  input wire logic rd_data_valid_o,
  input wire logic rd_last_cyc_n_o,
  input wire logic rd_fifo_empty_n_o,
  input wire logic rd_fifo_almost_empty_n_o,
  input wire logic rd_fifo_full_n_o,
  // requests and actions
  input wire logic stop_burst_n_i,
  input wire logic burst_stop_o,
  input wire logic tgt_abort_req_i,
  input wire logic tgt_retry_req_n_i,
  input wire logic tgt_is_mem_write_i,
  input wire logic tgt_abort_o,
  input wire logic tgt_retry_o,
  input wire logic dt_start_o,
  input wire logic dt_new_txn_o,
  input wire logic disc_timer_exp_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////
  chk_full_blocks: assert property (!rd_fifo_full_n_o && rd_data_en_n_i |=> !rd_fifo_full_n_o && !pci_rd_ready_o)
    else $error("read fifo left full state without a pop");
  chk_empty_aempty: assert property (!rd_fifo_empty_n_o |-> !rd_fifo_almost_empty_n_o)
    else $error("almost empty flag high while empty");
  chk_pop_cause: assert property (rd_data_valid_o |-> $past(!rd_data_en_n_i && rd_fifo_empty_n_o))
    else $error("read data without a pop of a non-empty fifo");
  chk_last_word: assert property (!rd_last_cyc_n_o |-> rd_data_valid_o)
    else $error("last marker without read data");
  chk_abort_take: assert property (tgt_abort_req_i [*2] |-> ##[1:2] tgt_abort_o)
    else $error("abort not taken after two held cycles");
  chk_retry_on: assert property (!tgt_retry_req_n_i [*3] |-> ##[0:1] tgt_retry_o)
    else $error("retry not signalled while held");
  chk_stop_on: assert property (!stop_burst_n_i [*3] |-> ##[0:1] burst_stop_o)
    else $error("burst not stopped while held");
  chk_mem_post: assert property (tgt_is_mem_write_i [*4] |-> !dt_start_o)
    else $error("delayed transaction started for a memory write");
  chk_new_txn: assert property (dt_new_txn_o |-> dt_start_o && $past(!disc_timer_exp_n_o))
    else $error("new transaction without prior expiry");
  chk_timer_runs: assert property (dt_start_o |=> disc_timer_exp_n_o [*8])
    else $error("discard timer expired right after start");
  ////////////////////////////////////////////////////////////
  cov_abort: cover property (tgt_abort_o);
  cov_last: cover property (!rd_last_cyc_n_o);
  cov_new: cover property (dt_new_txn_o);
  cov_stop: cover property (burst_stop_o);
endmodule : pci_user_ctl_chk
bind pci_user_ctl pci_user_ctl_chk i_pci_user_ctl_chk (.*);
`default_nettype wire

/* File: verification/pci_user_ctl_test.sv */
// self-checking bench for pci_user_ctl: apb registers, read fifo, target requests, serial status
// assumes zero-wait apb, registered flags and a discard limit shortened to 20 cycles
`default_nettype none
`include "pci_user_consts.svh"
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module pci_user_ctl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 8;
  logic        ref_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, pci_rd_data_i = 32'h0, prdata_o, rd_data_o;
  logic        pci_rd_valid_i = 1'b0, pci_rd_last_i = 1'b0, rd_data_en_n_i = 1'b1, dt_done_i = 1'b0;
  logic        tgt_is_mem_write_i = 1'b0, evt_tabort_i = 1'b0, evt_serr_i = 1'b0, evt_perr_i = 1'b0;
  logic        stat_shift_en_n_i = 1'b1, go = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic        stop_burst_n_i, tgt_abort_req_i, tgt_retry_req_n_i, tgt_delayed_req_i, pready_o, pslverr_o;
  logic        pci_rd_ready_o, rd_data_valid_o, rd_last_cyc_n_o, rd_fifo_empty_n_o, rd_fifo_almost_empty_n_o;
  logic        rd_fifo_full_n_o, burst_stop_o, tgt_abort_o, tgt_retry_o, dt_start_o, dt_new_txn_o;
  logic        disc_timer_exp_n_o, status_o;
  logic [2:0]  ev, mask;
  logic [31:0] words[$];
  int          failures = 0, n_compared = 0, seed = 55, cycles = 0, starts = 0, news = 0, n;

  pci_user_ctl #(.WIDTH(32), .DEPTH(DEPTH), .DISCARD_LIMIT(15'h0014)) i_pci_user_ctl (.*);
  user_req_model i_user_req_model (
    .ref_clk_i      (ref_clk_i),
    .srst_i         (srst_i),
    .go_i           (go),
    .kind_i         (kind),
    .full_n_i       (rd_fifo_full_n_o),
    .stop_burst_n_o (stop_burst_n_i),
    .abort_req_o    (tgt_abort_req_i),
    .retry_req_n_o  (tgt_retry_req_n_i),
    .delayed_req_o  (tgt_delayed_req_i)
  );

  always #5 ref_clk_i = ~ref_clk_i;
  // counts pulses at the edge, before that edge's updates land
  always @(posedge ref_clk_i) begin
    cycles++;
    starts += int'(dt_start_o === 1'b1);
    news += int'(dt_new_txn_o === 1'b1);
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] stat_word(input logic [2:0] evs, input logic [2:0] fl, input logic [2:0] tg);
    stat_word = 32'h0;
    stat_word[`STAT_EVT_LSB +: 3] = evs;
    stat_word[`STAT_EMPTY_BIT +: 3] = fl;
    stat_word[`STAT_ABORT_BIT +: 3] = tg;
  endfunction : stat_word

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask : chk_rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic req(input logic [1:0] k);
    @(posedge ref_clk_i);
    go <= 1'b1;
    kind <= k;
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : req

  task automatic wrap_up;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    chk_rd(`REG_CTRL_OFS, 32'h00000007, 1'b0);
    chk_rd(`REG_STATUS_OFS, stat_word(3'h0, 3'b100, 3'h0), 1'b0);
    chk_rd(12'h0FC, 32'h0, 1'b1);
    wr(`REG_TIMER_OFS, 32'h00007FFF);
    chk_rd(`REG_TIMER_OFS, 32'h0, 1'b0);
    // fill past full: the extra word must not be taken
    for (int k = 0; k < DEPTH; k++) begin
      words.push_back($random(seed));
      @(posedge ref_clk_i);
      pci_rd_valid_i <= 1'b1;
      pci_rd_data_i <= words[k];
      pci_rd_last_i <= (k == DEPTH - 1);
    end
    @(posedge ref_clk_i);
    pci_rd_data_i <= $random(seed);
    @(posedge ref_clk_i);
    pci_rd_valid_i <= 1'b0;
    #1 `CHK({rd_fifo_full_n_o, pci_rd_ready_o}, 2'b00)
    @(posedge ref_clk_i);
    rd_data_en_n_i <= 1'b0;
    for (int k = 1; k <= DEPTH; k++) begin
      @(posedge ref_clk_i);
      #1 `CHK({rd_data_valid_o, rd_data_o}, {1'b1, words[k-1]})
      `CHK(rd_last_cyc_n_o, (k != DEPTH))
      `CHK({rd_fifo_empty_n_o, rd_fifo_almost_empty_n_o}, {(k != DEPTH), (DEPTH - k > 4)})
    end
    @(posedge ref_clk_i);
    rd_data_en_n_i <= 1'b1;
    #1 `CHK(rd_data_valid_o, 1'b0)
    for (int k = 0; k < 3; k += 2) begin
      req(2'(k));
      `CHK((k == 0) ? burst_stop_o : tgt_retry_o, 1'b1)
      repeat (3) @(posedge ref_clk_i);
      #1 `CHK({burst_stop_o, tgt_retry_o}, 2'b00)
    end
    req(2'h1);
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK(tgt_abort_o, 1'b1)
    chk_rd(`REG_STATUS_OFS, stat_word(3'h0, 3'b100, 3'b001), 1'b0);
    wr(`REG_CTRL_OFS, 32'h00000017);
    @(posedge ref_clk_i);
    #1 `CHK(tgt_abort_o, 1'b0)
    @(posedge ref_clk_i);
    tgt_is_mem_write_i <= 1'b1;
    req(2'h3);
    repeat (3) @(posedge ref_clk_i);
    tgt_is_mem_write_i <= 1'b0;
    #1 `CHK(starts, 0)
    req(2'h3);
    n = 0;
    while (disc_timer_exp_n_o !== 1'b0 && n < 60) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    `CHK({starts == 1, disc_timer_exp_n_o}, 2'b10)
    `CHK(n > 14 && n < 26, 1'b1)
    req(2'h3);
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK({news == 1, disc_timer_exp_n_o}, 2'b11)
    @(posedge ref_clk_i);
    dt_done_i <= 1'b1;
    @(posedge ref_clk_i);
    dt_done_i <= 1'b0;
    chk_rd(`REG_STATUS_OFS, stat_word(3'h0, 3'b100, 3'h0), 1'b0);
    for (int i = 0; i < 4; i++) begin
      {ev, mask} = 6'($random(seed));
      @(posedge ref_clk_i);
      {evt_perr_i, evt_serr_i, evt_tabort_i} <= ev;
      @(posedge ref_clk_i);
      {evt_perr_i, evt_serr_i, evt_tabort_i} <= 3'h0;
      wr(`REG_CTRL_OFS, {29'h0, mask});
      repeat (2) @(posedge ref_clk_i);
      #1 `CHK(status_o, |(ev & mask))
      chk_rd(`REG_STATUS_OFS, stat_word(ev, 3'b100, 3'h0), 1'b0);
      @(posedge ref_clk_i);
      stat_shift_en_n_i <= 1'b0;
      for (int b = 0; b < 4; b++) begin
        @(posedge ref_clk_i);
        #1 `CHK(status_o, ev[b % 3])
      end
      @(posedge ref_clk_i);
      stat_shift_en_n_i <= 1'b1;
      wr(`REG_STATUS_OFS, 32'h00000007);
    end
    wrap_up();
  end
endmodule : pci_user_ctl_test
`default_nettype wire
